// >>> led_sink_b_flash_control_tb.sv
/* Self-checking bench for the second sink control.
   Assumes US_CYC of 1, so one microsecond is one cycle. */
`timescale 1ns/10ps
`default_nettype none
`include "lsbfc_regs.svh"
module led_sink_b_flash_control_tb;
	logic        sys_clk, rstn, reg_wr, reg_rd, psm_clear, hibernate, gpio_flash_trigger, lit;
	logic [7:0]  reg_addr, sink_level;
	logic [15:0] reg_wdata, reg_rdata;
	logic [5:0]  code;
	logic        powered;
	int          num_errors = 0;
	int          total_checks = 0;
	lsbfc_sink_b #(.US_CYC(1)) dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.psm_clear(psm_clear), .hibernate(hibernate), .gpio_flash_trigger(gpio_flash_trigger),
		.sink_powered(powered), .sink_b_current_code(code), .sink_level(sink_level));
	lsbfc_led_model led (.sys_clk(sys_clk), .sink_powered(powered), .sink_level(sink_level),
		.lit(lit));
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, e);
	endtask
	// The bound keeps a stuck level from hanging the run.
	task automatic wlev(input logic [7:0] v, output int n);
		n = 0;
		while (sink_level !== v) begin
			@(negedge sys_clk);
			n++;
			if (n > 40000) begin
				num_errors++;
				$display("BAD %0t level wait ran out", $time);
				end_sim();
			end
		end
	endtask
	task automatic regs_s();
		rd(8'hae, 16'h0000);
		rd(8'haf, 16'h0000);
		rd(8'h10, 16'h0000);
		wr(8'hae, 16'h902c);
		rd(8'hae, 16'h902c);
		chk(code, 6'h2c);
		hibernate = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(powered, 1'b1);
		wr(8'hae, 16'h802c);
		repeat (3) @(negedge sys_clk);
		chk(powered, 1'b0);
		hibernate = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(powered, 1'b1);
	endtask
	task automatic led_s();
		int n;
		wr(8'haf, 16'h6000);
		wlev(8'hff, n);
		chk(n < 4, 1'b1);
		wr(8'haf, 16'h4000);
		wlev(8'h00, n);
		chk(n < 4, 1'b1);
		wr(8'haf, 16'h2001);
		repeat (2000) @(negedge sys_clk);
		chk(sink_level inside {[8'h01:8'h03]}, 1'b1);
		psm_clear = 1'b1;
		@(negedge sys_clk);
		psm_clear = 1'b0;
		reg_addr = 8'haf;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, 16'h0000);
		wr(8'hae, 16'h8000);
		wr(8'haf, 16'h2002);
		repeat (2000) @(negedge sys_clk);
		chk(sink_level, 8'h01);
		wr(8'haf, 16'h0000);
	endtask
	task automatic flash_s();
		int n;
		wr(8'haf, 16'ha000);
		wlev(8'hff, n);
		chk(n < 4, 1'b1);
		wlev(8'h00, n);
		chk(n > 31990 && n < 32010, 1'b1);
		rd(8'haf, 16'h8000);
		wr(8'haf, 16'h9000);
		rd(8'haf, 16'h9000);
		wr(8'haf, 16'hc010);
		wr(8'haf, 16'he010);
		repeat (20) @(negedge sys_clk);
		chk(sink_level, 8'h00);
		gpio_flash_trigger = 1'b1;
		wlev(8'hff, n);
		chk(n < 8, 1'b1);
		gpio_flash_trigger = 1'b0;
		repeat (100) @(negedge sys_clk);
		gpio_flash_trigger = 1'b1;
		chk(lit, 1'b1);
		wlev(8'hfe, n);
		chk(n > 31880 && n < 31920, 1'b1);
		wlev(8'h00, n);
		chk(n > 1700 && n < 1960, 1'b1);
		wr(8'haf, 16'h0000);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		{rstn, reg_wr, reg_rd, psm_clear, hibernate, gpio_flash_trigger} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		regs_s();
		led_s();
		flash_s();
		end_sim();
	end
endmodule // led_sink_b_flash_control_tb
bind lsbfc_sink_b lsbfc_props u_props (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.psm_clear(psm_clear), .sink_powered(sink_powered), .sink_level(sink_level));
`default_nettype wire

// >>> lsbfc_led_model.sv
/* Behavioural LED string on the second sink pin.
   Assumes it watches the analogue sink controls. */
`timescale 1ns/10ps
`default_nettype none
module lsbfc_led_model (
	input wire logic       sys_clk,
	input wire logic       sink_powered,
	input wire logic [7:0] sink_level,
	output var logic       lit
);
	always_ff @(posedge sys_clk) begin
		lit <= sink_powered && sink_level != 8'h00;
	end
endmodule // lsbfc_led_model
`default_nettype wire

// >>> lsbfc_pkg.sv
/*
 * Types for the second LED sink control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package lsbfc_pkg;
	typedef enum logic {
		LSBFC_FL_IDLE,
		LSBFC_FL_PULSE
	} lsbfc_flash_state_type;
endpackage
`default_nettype wire

// >>> lsbfc_properties.sv
/* Port checker for the second sink control.
   Assumes it is bound to lsbfc_sink_b with US_CYC shortened. */
`timescale 1ns/10ps
`default_nettype none
module lsbfc_props (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        rstn,
	// Register port and power state machine clear.
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        psm_clear,
	// Sink controls.
	input wire logic        sink_powered,
	input wire logic [7:0]  sink_level
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire logic unm = reg_rd && reg_addr != 8'hae && reg_addr != 8'haf;
	wire logic top = sink_level == 8'hff;
	unmapped_read_a: assert property (unm |=> reg_rdata == 16'h0000) else $error("bad read");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	clear_unpowers_a: assert property (psm_clear |-> ##2 !sink_powered) else $error("still on");
	clear_zero_a: assert property (psm_clear ##1 (reg_rd && !reg_wr)
		|=> reg_rdata == 16'h0000) else $error("not cleared");
	dark_unpowered_a: assert property (!sink_powered [*3] |-> sink_level == 8'h00) else $error("lit");
	flash_start_a: assert property (reg_wr && reg_addr == 8'haf
		&& reg_wdata[15:13] == 3'b101 && sink_powered && sink_level == 8'h00 && !psm_clear
		##1 sink_powered |-> ##[1:3] top) else $error("no flash");
	pulse_hold_a: assert property ($rose(top) ##1 (sink_powered && !reg_wr && !psm_clear) [*4] |-> top)
		else $error("pulse cut");
	ramp_step_a: assert property (sink_powered && $past(sink_powered) && !top
		&& sink_level != 8'h00 && sink_level != $past(sink_level)
		|-> sink_level == $past(sink_level) + 8'h01
		|| sink_level == $past(sink_level) - 8'h01) else $error("ramp jump");
	cover property ($rose(top));
	cover property ($fell(sink_powered));
	cover property (unm);
endmodule // lsbfc_props
`default_nettype wire

// >>> lsbfc_regs.svh
/*
 * Register offsets, field positions, reset values and times for the second LED sink control.
 * Assumes it is included by bare name; times are in microseconds, the clock period in ns.
 */
`ifndef LSBFC_REGS_SVH
`define LSBFC_REGS_SVH

`define LSBFC_ADDR_LEVEL      8'hae
`define LSBFC_ADDR_FLASH      8'haf

`define LSBFC_POWER_ON_BIT    15
`define LSBFC_SLEEP_BIT       12
`define LSBFC_CODE_MSB        5
`define LSBFC_FUNC_BIT        15
`define LSBFC_TRIGSRC_BIT     14
`define LSBFC_DRIVE_BIT       13
`define LSBFC_REPEAT_BIT      12
`define LSBFC_LEN_LSB         8
`define LSBFC_FALL_LSB        4
`define LSBFC_RISE_LSB        0

`define LSBFC_CODE_RESET      6'h00
`define LSBFC_FIELD2_RESET    2'h0

`define LSBFC_CLK_NS          8
`define LSBFC_LEN0_US         32000
`define LSBFC_LEN1_US         64000
`define LSBFC_LEN2_US         96000
`define LSBFC_LEN3_US         1024000
`define LSBFC_LED_RAMP1_US    250000
`define LSBFC_LED_RAMP2_US    500000
`define LSBFC_LED_RAMP3_US    1000000
`define LSBFC_FL_RAMP1_US     1950
`define LSBFC_FL_RAMP2_US     3910
`define LSBFC_FL_RAMP3_US     7800
`define LSBFC_REPEAT_US       4000000
`define LSBFC_RAMP_STEPS      255
`define LSBFC_LEVEL_FULL      8'hff
`define LSBFC_LEVEL_OFF       8'h00

`endif

// >>> lsbfc_sink_b.sv
/*
 * Control logic of the second constant-current LED sink: register pair, flash sequencing,
 * periodic repeat and on/off ramps of the drive level.
 * Assumes the control interface hands in one-cycle read and write strobes on sys_clk, and that
 * the power state machine gives a one-cycle clear pulse and a hibernate level on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "lsbfc_regs.svh"

module lsbfc_sink_b #(
	parameter int          US_CYC        = 1000 / `LSBFC_CLK_NS,
	parameter logic        DRIVE_DEFAULT = 1'b0
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Register port of the control interface.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Power state machine.
	input  wire logic        psm_clear,
	input  wire logic        hibernate,
	// GPIO pin carrying the flash trigger function.
	input  wire logic        gpio_flash_trigger,
	// Analogue sink controls for the second sink pin.
	output logic             sink_powered,
	output logic      [5:0]  sink_b_current_code,
	output logic      [7:0]  sink_level
);

	logic        pwr_r, pwr_nxt, sleep_r, sleep_nxt;
	logic [5:0]  code_r, code_nxt;
	logic        func_r, func_nxt, trig_r, trig_nxt, drive_r, drive_nxt, rep_r, rep_nxt;
	logic [1:0]  len_r, len_nxt, fall_r, fall_nxt, rise_r, rise_nxt;
	logic        g1_r, g2_r, g3_r;
	lsbfc_pkg::lsbfc_flash_state_type st_r, st_nxt;
	logic [31:0] dur_r, dur_nxt, per_r, per_nxt, step_r, step_nxt;
	logic [7:0]  level_r, level_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic        gate_r, gate_nxt;

	function automatic logic [31:0] len_cycles(input logic [1:0] c);
		int us;
		case (c)
			2'd0:    us = `LSBFC_LEN0_US;
			2'd1:    us = `LSBFC_LEN1_US;
			2'd2:    us = `LSBFC_LEN2_US;
			default: us = `LSBFC_LEN3_US;
		endcase
		return 32'(us * US_CYC);
	endfunction

	// Cycles per one-level ramp step; code 00 never reaches here.
	function automatic logic [31:0] step_cycles(input logic [1:0] c, input logic flash);
		int us;
		case (c)
			2'd1:    us = flash ? `LSBFC_FL_RAMP1_US : `LSBFC_LED_RAMP1_US;
			2'd2:    us = flash ? `LSBFC_FL_RAMP2_US : `LSBFC_LED_RAMP2_US;
			default: us = flash ? `LSBFC_FL_RAMP3_US : `LSBFC_LED_RAMP3_US;
		endcase
		us = (us * US_CYC) / `LSBFC_RAMP_STEPS;
		return (us < 1) ? 32'd1 : 32'(us);
	endfunction

	logic        wr_lvl, wr_fl, sw_rise, gpio_rise, per_hit, trigger, pulse_end;
	logic        enabled, want_on, ramp_up;
	logic [7:0]  target;
	logic [1:0]  rcode;

	always_comb begin
		wr_lvl    = reg_wr && (reg_addr == `LSBFC_ADDR_LEVEL);
		wr_fl     = reg_wr && (reg_addr == `LSBFC_ADDR_FLASH);
		// Software rising edge.
		// The write is judged by the mode and source it sets, so one write can arm and fire.
		sw_rise   = wr_fl && reg_wdata[`LSBFC_FUNC_BIT] && !reg_wdata[`LSBFC_TRIGSRC_BIT]
			&& reg_wdata[`LSBFC_DRIVE_BIT] && !drive_r;
		gpio_rise = g2_r && !g3_r;
		per_hit   = func_r && rep_r && (per_r == 32'(`LSBFC_REPEAT_US * US_CYC) - 32'd1);
		// Trigger source select; drive ignored under GPIO source.
		trigger   = (st_r == lsbfc_pkg::LSBFC_FL_IDLE)
			&& (sw_rise || (func_r && trig_r && gpio_rise) || per_hit);
		// Duration end; all four length codes.
		pulse_end = (st_r == lsbfc_pkg::LSBFC_FL_PULSE) && (dur_r == len_cycles(len_r) - 32'd1);

		pwr_nxt   = pwr_r;
		sleep_nxt = sleep_r;
		code_nxt  = code_r;
		func_nxt  = func_r;
		trig_nxt  = trig_r;
		drive_nxt = drive_r;
		rep_nxt   = rep_r;
		len_nxt   = len_r;
		fall_nxt  = fall_r;
		rise_nxt  = rise_r;
		// Hardware clears drive; a write in the same cycle wins.
		if (pulse_end)
			drive_nxt = 1'b0;
		if (wr_lvl) begin
			pwr_nxt   = reg_wdata[`LSBFC_POWER_ON_BIT];
			sleep_nxt = reg_wdata[`LSBFC_SLEEP_BIT];
			code_nxt  = reg_wdata[`LSBFC_CODE_MSB:0];
		end
		if (wr_fl) begin
			func_nxt  = reg_wdata[`LSBFC_FUNC_BIT];
			trig_nxt  = reg_wdata[`LSBFC_TRIGSRC_BIT];
			drive_nxt = reg_wdata[`LSBFC_DRIVE_BIT];
			rep_nxt   = reg_wdata[`LSBFC_REPEAT_BIT];
			len_nxt   = reg_wdata[`LSBFC_LEN_LSB+1:`LSBFC_LEN_LSB];
			fall_nxt  = reg_wdata[`LSBFC_FALL_LSB+1:`LSBFC_FALL_LSB];
			rise_nxt  = reg_wdata[`LSBFC_RISE_LSB+1:`LSBFC_RISE_LSB];
		end

		st_nxt  = st_r;
		dur_nxt = 32'd0;
		per_nxt = (func_r && rep_r && !per_hit) ? per_r + 32'd1 : 32'd0;
		case (st_r)
			lsbfc_pkg::LSBFC_FL_IDLE: begin
				if (trigger)
					st_nxt = lsbfc_pkg::LSBFC_FL_PULSE;
			end
			lsbfc_pkg::LSBFC_FL_PULSE: begin
				dur_nxt = dur_r + 32'd1;
				if (pulse_end || !func_r)
					st_nxt = lsbfc_pkg::LSBFC_FL_IDLE;
			end
			default: st_nxt = lsbfc_pkg::LSBFC_FL_IDLE;
		endcase

		enabled = pwr_r && (!hibernate || sleep_r);
		// Function select; LED mode ignores source; drive level.
		want_on = func_r ? (st_r == lsbfc_pkg::LSBFC_FL_PULSE) : drive_r;
		target  = (enabled && want_on) ? `LSBFC_LEVEL_FULL : `LSBFC_LEVEL_OFF;
		ramp_up = target > level_r;
		// Flash switch-on has no ramp setting, so it is always instant.
		rcode   = ramp_up ? (func_r ? 2'd0 : rise_r) : fall_r;
		level_nxt = level_r;
		step_nxt  = 32'd0;
		if (level_r != target) begin
			// LED fall; flash fall; LED rise; code 00 or disabled.
			if (rcode == 2'd0 || !enabled)
				level_nxt = target;
			else if (step_r >= step_cycles(rcode, func_r) - 32'd1)
				level_nxt = ramp_up ? level_r + 8'h01 : level_r - 8'h01;
			else
				step_nxt = step_r + 32'd1;
		end
		gate_nxt = enabled;

		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				`LSBFC_ADDR_LEVEL: rdata_nxt = {pwr_r, 2'h0, sleep_r, 6'h00, code_r};
				`LSBFC_ADDR_FLASH: rdata_nxt = {func_r, trig_r, drive_r, rep_r, 2'h0, len_r,
					2'h0, fall_r, 2'h0, rise_r};
				default:           rdata_nxt = 16'h0000;
			endcase
		end

		if (psm_clear) begin
			pwr_nxt   = 1'b0;
			sleep_nxt = 1'b0;
			code_nxt  = `LSBFC_CODE_RESET;
			func_nxt  = 1'b0;
			trig_nxt  = 1'b0;
			drive_nxt = DRIVE_DEFAULT;
			rep_nxt   = 1'b0;
			len_nxt   = `LSBFC_FIELD2_RESET;
			fall_nxt  = `LSBFC_FIELD2_RESET;
			rise_nxt  = `LSBFC_FIELD2_RESET;
			st_nxt    = lsbfc_pkg::LSBFC_FL_IDLE;
			per_nxt   = 32'd0;
			dur_nxt   = 32'd0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pwr_r   <= 1'b0;
			sleep_r <= 1'b0;
			code_r  <= `LSBFC_CODE_RESET;
			func_r  <= 1'b0;
			trig_r  <= 1'b0;
			drive_r <= DRIVE_DEFAULT;
			rep_r   <= 1'b0;
			len_r   <= `LSBFC_FIELD2_RESET;
			fall_r  <= `LSBFC_FIELD2_RESET;
			rise_r  <= `LSBFC_FIELD2_RESET;
			g1_r    <= 1'b0;
			g2_r    <= 1'b0;
			g3_r    <= 1'b0;
			st_r    <= lsbfc_pkg::LSBFC_FL_IDLE;
			dur_r   <= 32'd0;
			per_r   <= 32'd0;
			step_r  <= 32'd0;
			level_r <= `LSBFC_LEVEL_OFF;
			rdata_r <= 16'h0000;
			gate_r  <= 1'b0;
		end else begin
			pwr_r   <= pwr_nxt;
			sleep_r <= sleep_nxt;
			code_r  <= code_nxt;
			func_r  <= func_nxt;
			trig_r  <= trig_nxt;
			drive_r <= drive_nxt;
			rep_r   <= rep_nxt;
			len_r   <= len_nxt;
			fall_r  <= fall_nxt;
			rise_r  <= rise_nxt;
			g1_r    <= gpio_flash_trigger;
			g2_r    <= g1_r;
			g3_r    <= g2_r;
			st_r    <= st_nxt;
			dur_r   <= dur_nxt;
			per_r   <= per_nxt;
			step_r  <= step_nxt;
			level_r <= level_nxt;
			rdata_r <= rdata_nxt;
			gate_r  <= gate_nxt;
		end
	end

	// Current code goes straight to the analogue DAC.
	assign sink_b_current_code = code_r;
	assign reg_rdata           = rdata_r;
	assign sink_powered        = gate_r;
	assign sink_level          = level_r;

endmodule // lsbfc_sink_b

`default_nettype wire
